// ### shared/seg_port_regs.svh
// Purpose: register offsets, field positions and reset values for the segment input ports
// Assumes: included by bare name
// Notes: offsets are register indices on the plain register port
`ifndef SEG_PORT_REGS_SVH
`define SEG_PORT_REGS_SVH
`define ADDR_W 9
`define OFF_PORT_E 9'h009
`define OFF_DIR_E 9'h089
`define OFF_PORT_F 9'h107
`define OFF_SEG_EN 9'h10d
`define OFF_DIR_F 9'h187
`define OFF_PORT_G 9'h108
`define OFF_DIR_G 9'h188
`define RST_PORT 8'h00
`define RST_DIR 8'hff
`define RST_SEG_EN 8'hff
`define RST_ZERO 8'h00
`define SE_BIT_G05 1
`define SE_BIT_G09 2
`define SE_BIT_G12 3
`define SE_BIT_G16 4
`define SE_BIT_G20 5
`define SE_BIT_G27 6
`define PIN_E_G09_LO 4
`define PIN_E_TOP 7
`define PIN_F_G16_LO 4
`define PIN_G_TOP 7
`endif

// ### shared/seg_port_pkg.sv
// Purpose: shared types for the segment input ports
// Assumes: none
// Notes: port selector used by the port and direction decode functions
package seg_port_pkg;
  typedef enum logic [1:0] {
    sel_none,
    sel_e,
    sel_f,
    sel_g
  } port_sel_t;
  typedef logic [7:0] byte_t;
endpackage

// ### core/pin_sync.sv
// Purpose: three-flop synchroniser with agreement filter for one pin byte
// Assumes: pins are asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] stage_c;

  // Metastability chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_a <= '0;
      stage_b <= '0;
      stage_c <= '0;
    end else begin
      stage_a <= pin_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  // Change accepted once stages two and three agree, per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          level[i] <= 1'b0;
        end else if (stage_b[i] == stage_c[i]) begin
          level[i] <= stage_c[i];
        end
      end
    end
  endgenerate
endmodule

// ### core/seg_input_ports.sv
// Purpose: ports E, F, G as digital inputs shared with LCD segment outputs
// Assumes: one instruction clock; register port with read data one cycle later
// Notes: segment enable overrides direction; latch writes are read-modify-write
`timescale 1ns/1ps
`include "seg_port_regs.svh"

// Notes on behaviour
// R1 - Port E has eight digital input pins, each shared with a segment driver output.
// R2 - After reset every pin of ports E, F and G belongs to the segment driver.
// R3 - A pin turns digital input only while its segment enable bit is clear.
// R4 - A set segment enable bit masks the direction bits of its pins.
// R5 - Port E bits 0 to 6 are segments 5 to 11 and bit 7 is segment 27.
// R6 - Port F bits 0 to 7 are segments 12 to 19, released by groups 12 and 16.
// R7 - Port G bits 0 to 6 are segments 20 to 26 and bit 7 is segment 28.
// R8 - The group 27 bit owns port E bit 7 and port G bit 7.
// R9 - Port E bits 0 to 6 are released by the groups at segments 5 and 9.
// R10 - A port read returns pin levels and a port write goes only to the latch.
// R11 - A port write reads the pins, merges the value and writes all latch bits.
// R12 - Writes commit at the end of the cycle and reads sample at its start.
// R13 - Software should place a non-accessing cycle between a port write and its read.
// R14 - A set direction bit floats the pin and a clear bit drives the latch out.
// R15 - Each segment enable bit is exported as a group ownership signal.
module seg_input_ports #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output seg_port_pkg::byte_t rdata,
  input wire logic [WIDTH-1:0] pin_e_in,
  input wire logic [WIDTH-1:0] pin_f_in,
  input wire logic [WIDTH-1:0] pin_g_in,
  output logic [WIDTH-1:0] pin_e_out,
  output logic [WIDTH-1:0] pin_f_out,
  output logic [WIDTH-1:0] pin_g_out,
  output logic [WIDTH-1:0] pin_e_oe,
  output logic [WIDTH-1:0] pin_f_oe,
  output logic [WIDTH-1:0] pin_g_oe,
  output logic [WIDTH-1:0] seg_e_own,
  output logic [WIDTH-1:0] seg_f_own,
  output logic [WIDTH-1:0] seg_g_own,
  output logic [WIDTH-1:0] seg_group_own
);
  import seg_port_pkg::*;

  // Pin levels after the synchronisers
  logic [WIDTH-1:0] lvl_e;
  logic [WIDTH-1:0] lvl_f;
  logic [WIDTH-1:0] lvl_g;

  // Software-visible control registers
  logic [WIDTH-1:0] segment_pin_enable;
  logic [WIDTH-1:0] port_e_direction;
  logic [WIDTH-1:0] port_f_direction;
  logic [WIDTH-1:0] port_g_direction;

  // Output latches, kept even while the pin is owned or floating
  logic [WIDTH-1:0] latch_e;
  logic [WIDTH-1:0] latch_f;
  logic [WIDTH-1:0] latch_g;

  // Per-pin ownership, high while the LCD driver has the pin
  logic [WIDTH-1:0] own_e;
  logic [WIDTH-1:0] own_f;
  logic [WIDTH-1:0] own_g;

  // Port values as software reads them
  logic [WIDTH-1:0] input_port_e_value;
  logic [WIDTH-1:0] input_port_f_value;
  logic [WIDTH-1:0] input_port_g_value;

  // Register port decode results
  logic [WIDTH-1:0] next_rdata;
  port_sel_t wsel;
  port_sel_t wdir;

  // Port register decode, shared by write and read paths
  function automatic port_sel_t port_of(input logic [`ADDR_W-1:0] a);
    if (a == `OFF_PORT_E) begin
      return sel_e;
    end else if (a == `OFF_PORT_F) begin
      return sel_f;
    end else if (a == `OFF_PORT_G) begin
      return sel_g;
    end
    return sel_none;
  endfunction

  // Direction register decode, shared by write and read paths
  function automatic port_sel_t dir_of(input logic [`ADDR_W-1:0] a);
    if (a == `OFF_DIR_E) begin
      return sel_e;
    end else if (a == `OFF_DIR_F) begin
      return sel_f;
    end else if (a == `OFF_DIR_G) begin
      return sel_g;
    end
    return sel_none;
  endfunction

  // Segment enable register decode
  function automatic logic is_seg_en(input logic [`ADDR_W-1:0] a);
    return a == `OFF_SEG_EN;
  endfunction

  // Owned pins read low, so software never sees the segment waveform
  function automatic logic [WIDTH-1:0] visible(
    input logic [WIDTH-1:0] lvl,
    input logic [WIDTH-1:0] own
  );
    return lvl & ~own;
  endfunction

  // Driver on only for a clear direction bit on a pin the LCD does not own
  function automatic logic [WIDTH-1:0] drive_en(
    input logic [WIDTH-1:0] dir,
    input logic [WIDTH-1:0] own
  );
    return ~dir & ~own;
  endfunction

  // Pin synchronisers; pins are asynchronous to the core clock
  pin_sync #(.WIDTH(WIDTH)) u_sync_e (
    .clk(clk),
    .nrst(nrst),
    .pin_in(pin_e_in),
    .level(lvl_e)
  );
  pin_sync #(.WIDTH(WIDTH)) u_sync_f (
    .clk(clk),
    .nrst(nrst),
    .pin_in(pin_f_in),
    .level(lvl_f)
  );
  pin_sync #(.WIDTH(WIDTH)) u_sync_g (
    .clk(clk),
    .nrst(nrst),
    .pin_in(pin_g_in),
    .level(lvl_g)
  );

  // Per-pin ownership: each pin follows the one group bit that covers it
  genvar p;
  generate
    for (p = 0; p < WIDTH; p++) begin : g_own
      always_comb begin
        if (p == `PIN_E_TOP) begin
          own_e[p] = segment_pin_enable[`SE_BIT_G27]; // R8 R5 R1
        end else if (p >= `PIN_E_G09_LO) begin
          own_e[p] = segment_pin_enable[`SE_BIT_G09]; // R9 R5
        end else begin
          own_e[p] = segment_pin_enable[`SE_BIT_G05]; // R9 R5
        end
        if (p >= `PIN_F_G16_LO) begin
          own_f[p] = segment_pin_enable[`SE_BIT_G16]; // R6
        end else begin
          own_f[p] = segment_pin_enable[`SE_BIT_G12]; // R6
        end
        if (p == `PIN_G_TOP) begin
          own_g[p] = segment_pin_enable[`SE_BIT_G27]; // R8 R7
        end else begin
          own_g[p] = segment_pin_enable[`SE_BIT_G20]; // R7
        end
      end
    end
  endgenerate

  // Pin values as software sees them; owned pins read low
  always_comb begin
    input_port_e_value = visible(lvl_e, own_e); // R3
    input_port_f_value = visible(lvl_f, own_f); // R3
    input_port_g_value = visible(lvl_g, own_g); // R3
  end

  // Write decodes, qualified by the strobe
  assign wsel = wr_en ? port_of(addr) : sel_none;
  assign wdir = wr_en ? dir_of(addr) : sel_none;

  // Segment enable register, all groups owned after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      segment_pin_enable <= `RST_SEG_EN; // R2
    end else if (wr_en && is_seg_en(addr)) begin
      segment_pin_enable <= wdata; // R3
    end
  end

  // Direction registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_e_direction <= `RST_DIR;
      port_f_direction <= `RST_DIR;
      port_g_direction <= `RST_DIR;
    end else begin
      unique case (wdir)
        sel_e: port_e_direction <= wdata; // R14
        sel_f: port_f_direction <= wdata; // R14
        sel_g: port_g_direction <= wdata; // R14
        sel_none: begin
        end
      endcase
    end
  end

  // Output latches: software has already merged the pin levels into the
  // value, so the whole byte lands, input-pin bits included
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_e <= `RST_PORT;
      latch_f <= `RST_PORT;
      latch_g <= `RST_PORT;
    end else begin
      unique case (wsel)
        sel_e: latch_e <= wdata; // R10 R11 R12
        sel_f: latch_f <= wdata; // R10 R11 R12
        sel_g: latch_g <= wdata; // R10 R11 R12
        sel_none: begin
        end
      endcase
    end
  end

  // Pin drive enables: segment ownership beats direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_e_oe <= `RST_ZERO;
      pin_f_oe <= `RST_ZERO;
      pin_g_oe <= `RST_ZERO;
    end else begin
      pin_e_oe <= drive_en(port_e_direction, own_e); // R4 R14
      pin_f_oe <= drive_en(port_f_direction, own_f); // R4 R14
      pin_g_oe <= drive_en(port_g_direction, own_g); // R4 R14
    end
  end

  // Pin data: the latch is offered even while the driver is off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_e_out <= `RST_ZERO;
      pin_f_out <= `RST_ZERO;
      pin_g_out <= `RST_ZERO;
    end else begin
      pin_e_out <= latch_e; // R14
      pin_f_out <= latch_f; // R14
      pin_g_out <= latch_g; // R14
    end
  end

  // Ownership handed to the LCD driver, pin by pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_e_own <= `RST_SEG_EN; // R2
      seg_f_own <= `RST_SEG_EN; // R2
      seg_g_own <= `RST_SEG_EN; // R2
    end else begin
      seg_e_own <= own_e; // R15
      seg_f_own <= own_f; // R15
      seg_g_own <= own_g; // R15
    end
  end

  // Group bits exported as they stand in the register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_group_own <= `RST_SEG_EN; // R2
    end else begin
      seg_group_own <= segment_pin_enable; // R15
    end
  end

  // Read mux: pins sampled at the read cycle start; a read right after
  // a port write may still see the old pin level
  always_comb begin
    next_rdata = `RST_ZERO;
    unique case (port_of(addr))
      sel_e: next_rdata = input_port_e_value; // R10 R12 R13
      sel_f: next_rdata = input_port_f_value; // R10 R12
      sel_g: next_rdata = input_port_g_value; // R10 R12
      sel_none: begin
        if (is_seg_en(addr)) begin
          next_rdata = segment_pin_enable;
        end else begin
          unique case (dir_of(addr))
            sel_e: next_rdata = port_e_direction;
            sel_f: next_rdata = port_f_direction;
            sel_g: next_rdata = port_g_direction;
            sel_none: begin
            end
          endcase
        end
      end
    endcase
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `RST_ZERO;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= `RST_ZERO;
    end
  end
endmodule

// ### test/seg_ports_properties.sv
// Purpose: port-level checks for the segment input ports
// Assumes: single clock, async active-low reset
// Notes: watches a subset of the top ports, bound below
`timescale 1ns/1ps
`include "seg_port_regs.svh"
module seg_ports_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire seg_port_pkg::byte_t rdata,
  input wire logic [7:0] pin_e_out,
  input wire logic [7:0] pin_e_oe,
  input wire logic [7:0] seg_e_own,
  input wire logic [7:0] seg_f_own,
  input wire logic [7:0] seg_g_own,
  input wire logic [7:0] seg_group_own
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Short alias keeps the ownership maps readable
  wire logic [7:0] g = seg_group_own;
  property p_own_e; seg_e_own == {g[6], {3{g[2]}}, {4{g[1]}}}; endproperty
  a_own_e: assert property (p_own_e) else $error("port E ownership map wrong");
  property p_own_f; seg_f_own == {{4{g[4]}}, {4{g[3]}}}; endproperty
  a_own_f: assert property (p_own_f) else $error("port F ownership map wrong");
  property p_own_g; seg_g_own == {g[6], {7{g[5]}}}; endproperty
  a_own_g: assert property (p_own_g) else $error("port G ownership map wrong");
  property p_oe_mask; (pin_e_oe & seg_e_own) == 8'h00; endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("owned pin driven");
  property p_seg_wr; wr_en && addr == `OFF_SEG_EN |=> ##1 g == $past(wdata, 2); endproperty
  a_seg_wr: assert property (p_seg_wr) else $error("group ownership not updated");
  property p_rd_idle; !rd_en |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped; rd_en && addr == 9'h1ff |=> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_owned_rd;
    rd_en && addr == `OFF_PORT_E ##1 $stable(seg_e_own) |-> (rdata & seg_e_own) == 8'h00;
  endproperty
  a_owned_rd: assert property (p_owned_rd) else $error("owned pin read nonzero");
  property p_latch; wr_en && addr == `OFF_PORT_E |=> ##1 pin_e_out == $past(wdata, 2); endproperty
  a_latch: assert property (p_latch) else $error("latch not written");
  property p_dir;
    wr_en && addr == `OFF_DIR_E |=> ##1 pin_e_oe == (~$past(wdata, 2) & ~seg_e_own);
  endproperty
  a_dir: assert property (p_dir) else $error("pin enable wrong");
  // Main traffic kinds seen at least once
  c_seg_wr: cover property (wr_en && addr == `OFF_SEG_EN);
  c_port_rd: cover property (rd_en && addr == `OFF_PORT_E);
  c_dir_wr: cover property (wr_en && addr == `OFF_DIR_E);
endmodule
bind seg_input_ports seg_ports_properties i_seg_ports_properties (.clk, .nrst, .addr,
  .wdata, .wr_en, .rd_en, .rdata, .pin_e_out, .pin_e_oe, .seg_e_own, .seg_f_own,
  .seg_g_own, .seg_group_own);

// ### test/seg_pin_model.sv
// Purpose: outside pins plus the LCD segment driver
// Assumes: ownership high hands the pin to the LCD driver
// Notes: LCD level toggles every cycle, so it never looks stable
`timescale 1ns/1ps
module seg_pin_model (
  input wire logic clk,
  input wire logic [23:0] own,
  input wire logic [23:0] oe,
  input wire logic [23:0] drv,
  input wire logic [23:0] ext,
  output logic [23:0] pin
);
  logic [23:0] lcd = '0;
  // Segment waveform stand-in
  always @(posedge clk) lcd <= ~lcd;
  // LCD beats latch, latch beats outside world
  assign pin = (own & lcd) | (~own & oe & drv) | (~own & ~oe & ext);
endmodule

// ### test/tb.sv
// Purpose: self-checking bench for the segment input ports
// Assumes: pins settle through the sync within 6 cycles
// Notes: reads are scored through a queue of expected values
`timescale 1ns/1ps
`include "seg_port_regs.svh"
module tb;
  import seg_port_pkg::*;
  logic clk = 0, nrst = 0, wr_en = 0, rd_en = 0, pend = 0;
  logic [8:0] addr = '0;
  logic [7:0] wdata = '0, ee = '0, ef = '0, eg = '0, s, d;
  logic [7:0] pe, pf, pg, oe_e, oe_f, oe_g, out_e, out_f, out_g, own_e, own_f, own_g, grp;
  logic [23:0] m;
  byte_t rdata;
  byte_t exp_q[$];
  int err_count = 0, check_count = 0, seed = 16722, cyc = 0;
  always #5 clk = ~clk;
  seg_input_ports i_seg_input_ports (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_e_in(pe), .pin_f_in(pf),
    .pin_g_in(pg), .pin_e_out(out_e), .pin_f_out(out_f), .pin_g_out(out_g),
    .pin_e_oe(oe_e), .pin_f_oe(oe_f), .pin_g_oe(oe_g), .seg_e_own(own_e),
    .seg_f_own(own_f), .seg_g_own(own_g), .seg_group_own(grp));
  seg_pin_model i_seg_pin_model (.clk(clk), .own({own_g, own_f, own_e}),
    .oe({oe_g, oe_f, oe_e}), .drv({out_g, out_f, out_e}), .ext({eg, ef, ee}),
    .pin({pg, pf, pe}));
  function automatic logic [23:0] mask(logic [7:0] v);
    return {v[6], {7{v[5]}}, {4{v[4]}}, {4{v[3]}}, v[6], {3{v[2]}}, {4{v[1]}}};
  endfunction
  task automatic chk(string n, logic [23:0] e, logic [23:0] v);
    check_count++;
    if (v !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask
  // Read data stands only in the slot after the strobe
  always @(posedge clk) pend <= rd_en;
  always @(negedge clk) begin
    if (pend) begin
      chk("rdata", 24'(exp_q.pop_front()), 24'(rdata));
    end
  end
  // Hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wt(1);
    chk("seg_group_own", 24'(`RST_SEG_EN), 24'(grp));
    chk("seg_own", 24'hff_ffff, {own_g, own_f, own_e});
    chk("pin_oe", 24'h00_0000, {oe_g, oe_f, oe_e});
    rd(`OFF_SEG_EN, `RST_SEG_EN);
    rd(`OFF_DIR_E, `RST_DIR);
    rd(`OFF_DIR_F, `RST_DIR);
    rd(`OFF_PORT_E, 8'h00);
    rd(9'h1ff, 8'h00);
    // Clear each group alone, then all of them
    for (int b = 1; b < 8; b++) begin
      s = (b == 7) ? 8'h00 : ~(8'h01 << b);
      wr(`OFF_SEG_EN, s);
      wt(2);
      m = mask(s);
      chk("seg_own", m, {own_g, own_f, own_e});
      chk("seg_group_own", 24'(s), 24'(grp));
      @(posedge clk);
      {eg, ef, ee} <= 24'($random(seed));
      wt(6);
      rd(`OFF_PORT_E, ee & ~m[7:0]);
      rd(`OFF_PORT_F, ef & ~m[15:8]);
      rd(`OFF_PORT_G, eg & ~m[23:16]);
      rd(`OFF_SEG_EN, s);
    end
    // Drive some pins from the latch, others from outside
    d = 8'($random(seed));
    wr(`OFF_DIR_E, d);
    wr(`OFF_DIR_G, ~d);
    wr(`OFF_PORT_F, d);
    wr(`OFF_PORT_G, d);
    wr(`OFF_PORT_E, ~d);
    wt(2);
    chk("pin_e_oe", {16'h0000, ~d}, 24'(oe_e));
    chk("pin_e_out", {16'h0000, ~d}, 24'(out_e));
    chk("pin_g_oe", {16'h0000, d}, 24'(oe_g));
    chk("pin_f_oe", 24'h00_0000, 24'(oe_f));
    chk("pin_fg_out", {8'h00, d, d}, {8'h00, out_g, out_f});
    wt(6);
    rd(`OFF_PORT_E, ~d | ee);
    rd(`OFF_PORT_F, ef);
    rd(`OFF_PORT_G, d | eg);
    rd(`OFF_DIR_G, ~d);
    wr(`OFF_SEG_EN, 8'hff);
    wt(2);
    chk("pin_oe", 24'h00_0000, {oe_g, oe_f, oe_e});
    wr(`OFF_DIR_F, d);
    rd(`OFF_DIR_F, d);
    wt(2);
    finish_test();
  end
endmodule
